//--- core/drso_pkg.sv
package drso_pkg;
  // ----------------------------------------------------------
  // Register map
  // ----------------------------------------------------------
  localparam logic [7:0]  ADDR_SHAPE  = 8'h00;
  localparam logic [7:0]  ADDR_OTCFG  = 8'h04;
  localparam logic [7:0]  ADDR_OTLVL  = 8'h08;
  localparam logic [7:0]  ADDR_OTTIME = 8'h0C;
  localparam logic [7:0]  ADDR_SELA   = 8'h10;
  localparam logic [7:0]  ADDR_SELB   = 8'h14;
  localparam logic [7:0]  ADDR_STAT   = 8'h18;
  localparam logic [7:0]  ADDR_MASK   = 8'h1C;
  localparam logic [7:0]  ADDR_LIVE   = 8'h20;
  localparam logic [3:0]  RST_SHAPE   = 4'h0;
  localparam logic [3:0]  RST_OTCFG   = 4'h0;
  localparam logic [9:0]  RST_OTLVL   = 10'h0A0;
  localparam logic [15:0] RST_OTTIME  = 16'h0064;
  localparam logic [7:0]  RST_SEL     = 8'h00;
  localparam logic [7:0]  SEL_OVERTQ  = 8'h0B;
  // Field positions.
  localparam int SH_POL  = 2;
  localparam int SH_LOSS = 3;
  localparam int OT_EN   = 0;
  localparam int OT_SCOPE = 1;
  localparam int OT_RESP = 2;
  localparam int OT_SRC  = 3;
  localparam int ST_OT   = 0;
  localparam int ST_HOLD = 1;
  localparam int ST_FLT  = 2;
  // ----------------------------------------------------------
  // Timing
  // ----------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int SCURVE_A_MS   = 200;
  localparam int SCURVE_C_MS   = 500;
  localparam int SCURVE_D_MS   = 1000;
  localparam int LOOKBACK_MS   = 400;
  localparam int SAMPLE_MS     = 10;
  localparam int HIST_DEPTH    = LOOKBACK_MS / SAMPLE_MS;
  localparam int BLINK_MS      = 250;
  localparam logic [11:0] REF_FULL = 12'hFFF;
  localparam logic [10:0] OT_HYST  = 11'h00A;
  typedef enum logic [0:0] {LOSS_FOLLOW, LOSS_HOLD} drso_loss_t;
endpackage : drso_pkg

//--- core/drso_top.sv
`timescale 1ns/1ps
module drso_top #(
  parameter int MS_TICK_CYCLES = drso_pkg::MS_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [11:0] ref_in,
  input  wire logic        stop_cmd,
  input  wire logic        running,
  input  wire logic        accelerating,
  input  wire logic [15:0] accel_rate,
  input  wire logic [9:0]  current_pct,
  input  wire logic [9:0]  torque_pct,
  input  wire logic        at_agreed_freq,
  input  wire logic        dc_braking,
  input  wire logic        fault_reset,
  output logic [11:0]      freq_cmd,
  output logic [15:0]      accel_rate_now,
  output logic             ref_hold,
  output logic             overtorque,
  output logic             alarm_blink,
  output logic             fault_display,
  output logic             inverter_off,
  output logic             fault_contact,
  output logic             multi_out_overtorque,
  output logic             irq
);
  // ----------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------
  logic [31:0] ms_cnt, next_ms_cnt;
  logic        ms_tick;
  always_comb begin
    ms_tick     = (ms_cnt == 32'(MS_TICK_CYCLES - 1));
    next_ms_cnt = ms_tick ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) ms_cnt <= 32'h0000_0000;
    else ms_cnt <= next_ms_cnt;
  end

  // ----------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------
  logic [3:0]  shape, next_shape, otcfg, next_otcfg;
  logic [9:0]  otlvl, next_otlvl;
  logic [15:0] ottime, next_ottime;
  logic [7:0]  sela, next_sela, selb, next_selb;
  logic [2:0]  status, next_status, mask, next_mask, events;
  logic [7:0]  awaddr, next_awaddr;
  logic [31:0] wdata, next_wdata;
  logic [3:0]  wstrb, next_wstrb;
  logic        aw_held, next_aw_held, w_held, next_w_held;
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata, live;
  logic        do_wr;
  logic [15:0] wmask;
  logic        ev_ot, ev_hold, ev_flt;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_awaddr  = awaddr;
    next_wdata   = wdata;
    next_wstrb   = wstrb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rresp   = s_axi_rresp;
    next_rdata   = s_axi_rdata;
    next_shape   = shape;
    next_otcfg   = otcfg;
    next_otlvl   = otlvl;
    next_ottime  = ottime;
    next_sela    = sela;
    next_selb    = selb;
    next_mask    = mask;
    next_status  = status | events;
    wmask        = {{8{wstrb[1]}}, {8{wstrb[0]}}};
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_wdata  = s_axi_wdata;
      next_wstrb  = s_axi_wstrb;
    end
    do_wr = aw_held && w_held && !s_axi_bvalid;
    if (do_wr) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = 2'b00;
      unique case (awaddr)
        drso_pkg::ADDR_SHAPE:  if (wstrb[0]) next_shape = wdata[3:0];
        drso_pkg::ADDR_OTCFG:  if (wstrb[0]) next_otcfg = wdata[3:0];
        drso_pkg::ADDR_OTLVL:  next_otlvl = (otlvl & ~wmask[9:0]) | (wdata[9:0] & wmask[9:0]);
        drso_pkg::ADDR_OTTIME: next_ottime = (ottime & ~wmask) | (wdata[15:0] & wmask);
        drso_pkg::ADDR_SELA:   if (wstrb[0]) next_sela = wdata[7:0];
        drso_pkg::ADDR_SELB:   if (wstrb[0]) next_selb = wdata[7:0];
        // Set wins: an event in the clearing cycle stays visible.
        drso_pkg::ADDR_STAT:   if (wstrb[0]) next_status = (status & ~wdata[2:0]) | events;
        drso_pkg::ADDR_MASK:   if (wstrb[0]) next_mask = wdata[2:0];
        drso_pkg::ADDR_LIVE:   next_bresp = 2'b00;
        default:               next_bresp = 2'b10;
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_axi_rvalid) begin
      next_rvalid = 1'b1;
      next_rresp  = 2'b00;
      unique case (s_axi_araddr)
        drso_pkg::ADDR_SHAPE:  next_rdata = {28'h000_0000, shape};
        drso_pkg::ADDR_OTCFG:  next_rdata = {28'h000_0000, otcfg};
        drso_pkg::ADDR_OTLVL:  next_rdata = {22'h00_0000, otlvl};
        drso_pkg::ADDR_OTTIME: next_rdata = {16'h0000, ottime};
        drso_pkg::ADDR_SELA:   next_rdata = {24'h00_0000, sela};
        drso_pkg::ADDR_SELB:   next_rdata = {24'h00_0000, selb};
        drso_pkg::ADDR_STAT:   next_rdata = {29'h0000_0000, status};
        drso_pkg::ADDR_MASK:   next_rdata = {29'h0000_0000, mask};
        drso_pkg::ADDR_LIVE:   next_rdata = live;
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      awaddr       <= 8'h00;
      wdata        <= 32'h0000_0000;
      wstrb        <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= 2'b00;
      s_axi_rdata  <= 32'h0000_0000;
      shape        <= drso_pkg::RST_SHAPE;
      otcfg        <= drso_pkg::RST_OTCFG;
      otlvl        <= drso_pkg::RST_OTLVL;
      ottime       <= drso_pkg::RST_OTTIME;
      sela         <= drso_pkg::RST_SEL;
      selb         <= drso_pkg::RST_SEL;
      status       <= 3'h0;
      mask         <= 3'h0;
    end else begin
      aw_held      <= next_aw_held;
      w_held       <= next_w_held;
      awaddr       <= next_awaddr;
      wdata        <= next_wdata;
      wstrb        <= next_wstrb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp  <= next_rresp;
      s_axi_rdata  <= next_rdata;
      shape        <= next_shape;
      otcfg        <= next_otcfg;
      otlvl        <= next_otlvl;
      ottime       <= next_ottime;
      sela         <= next_sela;
      selb         <= next_selb;
      status       <= next_status;
      mask         <= next_mask;
    end
  end

  assign irq = |(status & mask);
  assign events = (3'(ev_ot) << drso_pkg::ST_OT) | (3'(ev_hold) << drso_pkg::ST_HOLD) | (3'(ev_flt) << drso_pkg::ST_FLT);

  // ----------------------------------------------------------
  // S-curve shaping
  // ----------------------------------------------------------
  logic [9:0]  sc_ms, next_sc_ms, sc_len;
  logic [15:0] next_rate;
  logic [25:0] sc_prod;
  always_comb begin
    unique case (shape[1:0])
      2'b00:   sc_len = 10'(drso_pkg::SCURVE_A_MS);
      2'b01:   sc_len = 10'h000;
      2'b10:   sc_len = 10'(drso_pkg::SCURVE_C_MS);
      2'b11:   sc_len = 10'(drso_pkg::SCURVE_D_MS);
    endcase
    next_sc_ms = sc_ms;
    if (!accelerating) next_sc_ms = 10'h000;
    else if (ms_tick && sc_ms < sc_len) next_sc_ms = sc_ms + 10'h001;
    // Constant divisors keep this a multiplier, not a general divider.
    sc_prod = 26'(accel_rate) * 26'(sc_ms);
    next_rate = accel_rate;
    if (!accelerating) next_rate = 16'h0000;
    else if (sc_ms < sc_len) begin
      unique case (shape[1:0])
        2'b00:   next_rate = 16'(sc_prod / 26'(drso_pkg::SCURVE_A_MS));
        2'b10:   next_rate = 16'(sc_prod / 26'(drso_pkg::SCURVE_C_MS));
        2'b11:   next_rate = 16'(sc_prod / 26'(drso_pkg::SCURVE_D_MS));
        default: next_rate = accel_rate;
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sc_ms          <= 10'h000;
      accel_rate_now <= 16'h0000;
    end else begin
      sc_ms          <= next_sc_ms;
      accel_rate_now <= next_rate;
    end
  end

  // ----------------------------------------------------------
  // Reference polarity and loss hold
  // ----------------------------------------------------------
  logic [11:0] ref_lin, held, next_held, old_ref, next_freq;
  logic [11:0] hist [drso_pkg::HIST_DEPTH];
  logic [11:0] next_hist [drso_pkg::HIST_DEPTH];
  logic [5:0]  hptr, next_hptr;
  logic [3:0]  smp, next_smp;
  logic        hfull, next_hfull, lost, low_old;
  drso_pkg::drso_loss_t loss, next_loss;

  always_comb begin
    // The input is unsigned, so only positive levels exist here.
    ref_lin = shape[drso_pkg::SH_POL] ? drso_pkg::REF_FULL - ref_in : ref_in;
    next_hist  = hist;
    next_hptr  = hptr;
    next_hfull = hfull;
    next_smp   = smp;
    if (ms_tick) begin
      next_smp = (smp == 4'(drso_pkg::SAMPLE_MS - 1)) ? 4'h0 : smp + 4'h1;
      if (smp == 4'(drso_pkg::SAMPLE_MS - 1)) begin
        next_hist[hptr] = ref_lin;
        next_hptr = (hptr == 6'(drso_pkg::HIST_DEPTH - 1)) ? 6'h00 : hptr + 6'h01;
        if (hptr == 6'(drso_pkg::HIST_DEPTH - 1)) next_hfull = 1'b1;
      end
    end
    old_ref = hist[hptr];
    lost    = hfull && (16'(ref_lin) * 16'h000A < 16'(old_ref));
    low_old = 19'(old_ref) * 19'h0_0064 < 19'(drso_pkg::REF_FULL) * 19'h0_0005;
    next_loss = loss;
    next_held = held;
    ev_hold   = 1'b0;
    unique case (loss)
      drso_pkg::LOSS_FOLLOW: begin
        if (shape[drso_pkg::SH_LOSS] && running && !stop_cmd && lost && !low_old) begin
          next_loss = drso_pkg::LOSS_HOLD;
          next_held = 12'((19'(old_ref) * 19'h0_0050) / 19'h0_0064);
          ev_hold   = 1'b1;
        end
      end
      drso_pkg::LOSS_HOLD: begin
        if (stop_cmd || !shape[drso_pkg::SH_LOSS] || ref_lin > held) begin
          next_loss = drso_pkg::LOSS_FOLLOW;
        end
      end
    endcase
    next_freq = (loss == drso_pkg::LOSS_HOLD) ? held : ref_lin;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < drso_pkg::HIST_DEPTH; i++) hist[i] <= 12'h000;
      hptr     <= 6'h00;
      hfull    <= 1'b0;
      smp      <= 4'h0;
      loss     <= drso_pkg::LOSS_FOLLOW;
      held     <= 12'h000;
      freq_cmd <= 12'h000;
    end else begin
      hist     <= next_hist;
      hptr     <= next_hptr;
      hfull    <= next_hfull;
      smp      <= next_smp;
      loss     <= next_loss;
      held     <= next_held;
      freq_cmd <= next_freq;
    end
  end
  assign ref_hold = (loss == drso_pkg::LOSS_HOLD);

  // ----------------------------------------------------------
  // Overtorque detection
  // ----------------------------------------------------------
  logic [9:0]  ot_src;
  logic [15:0] ot_ms, next_ot_ms;
  logic [7:0]  bl_ms, next_bl_ms;
  logic        check, above, below, next_ot, next_fault, fault;
  logic        phase, next_phase, next_blink, next_mout;
  always_comb begin
    ot_src = otcfg[drso_pkg::OT_SRC] ? torque_pct : current_pct;
    check  = otcfg[drso_pkg::OT_EN] &&
             (otcfg[drso_pkg::OT_SCOPE] ? !dc_braking : at_agreed_freq);
    above  = ot_src >= otlvl;
    below  = 11'(ot_src) + drso_pkg::OT_HYST < 11'(otlvl);
    next_ot_ms = ot_ms;
    if (!check || !above) next_ot_ms = 16'h0000;
    else if (ms_tick && ot_ms < ottime) next_ot_ms = ot_ms + 16'h0001;
    next_ot = overtorque;
    if (!check) next_ot = 1'b0;
    else if (!overtorque && above && ot_ms >= ottime) next_ot = 1'b1;
    else if (overtorque && below) next_ot = 1'b0;
    ev_ot = next_ot && !overtorque;
    next_fault = fault;
    if (next_ot && otcfg[drso_pkg::OT_RESP]) next_fault = 1'b1;
    else if (fault_reset) next_fault = 1'b0;
    ev_flt = next_fault && !fault;
    next_bl_ms = bl_ms;
    next_phase = phase;
    if (ms_tick) begin
      next_bl_ms = (bl_ms == 8'(drso_pkg::BLINK_MS - 1)) ? 8'h00 : bl_ms + 8'h01;
      if (bl_ms == 8'(drso_pkg::BLINK_MS - 1)) next_phase = !phase;
    end
    // Alarm only blinks; the drive keeps running.
    next_blink = overtorque && !otcfg[drso_pkg::OT_RESP] && phase;
    next_mout  = overtorque && (sela == drso_pkg::SEL_OVERTQ || selb == drso_pkg::SEL_OVERTQ);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ot_ms                <= 16'h0000;
      overtorque           <= 1'b0;
      fault                <= 1'b0;
      bl_ms                <= 8'h00;
      phase                <= 1'b0;
      alarm_blink          <= 1'b0;
      multi_out_overtorque <= 1'b0;
    end else begin
      ot_ms                <= next_ot_ms;
      overtorque           <= next_ot;
      fault                <= next_fault;
      bl_ms                <= next_bl_ms;
      phase                <= next_phase;
      alarm_blink          <= next_blink;
      multi_out_overtorque <= next_mout;
    end
  end
  // A fault latches until fault_reset, even if torque drops.
  assign fault_display = fault;
  assign inverter_off  = fault;
  assign fault_contact = fault;
  // Flags sit above the command so that software can decode every field.
  assign live = {17'h0_0000, fault, overtorque, ref_hold, freq_cmd};

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  ot_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !otcfg[drso_pkg::OT_EN] |=> !overtorque) else $error("overtorque while disabled");
  ot_time_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(overtorque) |-> $past(ot_ms) >= ottime && $past(above)) else $error("overtorque too early");
  ot_hyst_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(overtorque) && $past(check) |-> $past(below)) else $error("cleared inside hysteresis");
  fault_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    overtorque && otcfg[drso_pkg::OT_RESP] |-> inverter_off && fault_contact) else $error("no fault");
  mout_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    multi_out_overtorque |-> $past(overtorque) && ($past(sela) == 8'h0B || $past(selb) == 8'h0B))
    else $error("multi output without code");
  hold_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ref_hold && stop_cmd |=> !ref_hold) else $error("hold kept on stop");
  follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ref_hold |=> freq_cmd == $past(ref_lin)) else $error("command not following");
  hold_val_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(ref_hold) |-> held == 12'((19'($past(old_ref)) * 19'h0_0050) / 19'h0_0064)) else $error("bad held value");
  pol_a: assert property (@(posedge aclk) disable iff (!aresetn)
    shape[drso_pkg::SH_POL] && !ref_hold |=> freq_cmd == 12'hFFF - $past(ref_in)) else $error("polarity wrong");
  scurve_a: assert property (@(posedge aclk) disable iff (!aresetn)
    shape[1:0] == 2'b01 && accelerating |=> accel_rate_now == $past(accel_rate)) else $error("s-curve not off");
endmodule : drso_top

//--- bench/drso_power_stage.sv
`timescale 1ns/1ps
// ----------------------------------------
// Power stage and motor model
// ----------------------------------------
// A shut-off output stops the motor and takes its current away, so a
// fault can never clear itself through the load.
module drso_power_stage (
  input  wire logic       aclk,
  input  wire logic       run_req,
  input  wire logic [9:0] load_pct,
  input  wire logic       inverter_off,
  output logic            running,
  output logic [9:0]      current_pct
);
  initial begin
    running = 1'b0;
    current_pct = 10'h000;
  end
  always @(posedge aclk) begin
    running <= run_req && !inverter_off;
    current_pct <= inverter_off ? 10'h000 : load_pct;
  end
endmodule : drso_power_stage

//--- bench/drive_ref_shaping_overtorque_test.sv
`timescale 1ns/1ps
module drive_ref_shaping_overtorque_test;
  // ----------------------------------------
  // Clock, pins and counters
  // ----------------------------------------
  // Times below are in scaled ms ticks, which keeps the run short.
  localparam int TICK  = 20;
  localparam int LIMIT = 100000;
  localparam int SC_MS [4] = '{200, 0, 500, 1000};
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [11:0] ref_in = 12'h000;
  logic        stop_cmd = 1'b0;
  logic        run_req = 1'b0;
  logic        accelerating = 1'b0;
  logic [15:0] accel_rate = 16'h0000;
  logic [9:0]  load_pct = 10'h000;
  logic [9:0]  torque_pct = 10'h000;
  logic        at_agreed_freq = 1'b0;
  logic        dc_braking = 1'b0;
  logic        fault_reset = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        running, ref_hold, overtorque, alarm_blink, fault_display, inverter_off;
  logic        fault_contact, multi_out_overtorque, irq;
  logic [9:0]  current_pct;
  logic [11:0] freq_cmd;
  logic [15:0] accel_rate_now;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          hi;
  always #25 aclk = ~aclk;
  drso_top #(.MS_TICK_CYCLES(TICK)) drso_top_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ref_in, .stop_cmd, .running, .accelerating, .accel_rate, .current_pct, .torque_pct,
    .at_agreed_freq, .dc_braking, .fault_reset, .freq_cmd, .accel_rate_now, .ref_hold, .overtorque,
    .alarm_blink, .fault_display, .inverter_off, .fault_contact, .multi_out_overtorque, .irq);
  drso_power_stage drso_power_stage_inst (.aclk, .run_req, .load_pct, .inverter_off, .running, .current_pct);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s is %h, not %h", $time, what, got, exp);
    end
  endtask : check
  task automatic ms(input int n);
    repeat (n * TICK) @(posedge aclk);
  endtask : ms
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), 32'(er), "bresp");
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er, input string what);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, exp, what);
    check(32'(s_axi_rresp), 32'(er), what);
    @(posedge aclk);
  endtask : rd
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      summarize();
    end
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(drso_pkg::ADDR_SHAPE, 32'h0000_0000, 2'h0, "shape");
    rd(drso_pkg::ADDR_OTLVL, 32'h0000_00A0, 2'h0, "level");
    rd(drso_pkg::ADDR_OTTIME, 32'h0000_0064, 2'h0, "time");
    rd(8'h40, 32'h0000_0000, 2'h2, "unmapped");
    wr(8'h40, 32'h0000_0001, 2'h2);
    run_req <= 1'b1;
    accel_rate <= 16'h1000;
    for (int i = 0; i < 4; i++) begin
      wr(drso_pkg::ADDR_SHAPE, 32'(i), 2'h0);
      accelerating <= 1'b1;
      ms(2);
      if (i != 1) check(32'(accel_rate_now < 16'h1000), 32'h1, "ramp start");
      if (i != 1) begin
        ms(SC_MS[i] - 4);
        check(32'(accel_rate_now < 16'h1000), 32'h1, "ramp mid");
      end
      ms(9);
      check(32'(accel_rate_now), 32'h0000_1000, "ramp end");
      accelerating <= 1'b0;
      ms(1);
    end
    ref_in <= 12'h400;
    wr(drso_pkg::ADDR_SHAPE, 32'h0000_0001, 2'h0);
    ms(1);
    check(32'(freq_cmd), 32'h0000_0400, "linear");
    ref_in <= 12'h010;
    ms(1);
    check(32'({ref_hold, freq_cmd}), 32'h0000_0010, "follow");
    wr(drso_pkg::ADDR_SHAPE, 32'h0000_0005, 2'h0);
    ms(1);
    check(32'(freq_cmd), 32'h0000_0FEF, "inverted");
    ref_in <= 12'h800;
    wr(drso_pkg::ADDR_SHAPE, 32'h0000_0009, 2'h0);
    wr(drso_pkg::ADDR_MASK, 32'h0000_0002, 2'h0);
    ms(410);
    ref_in <= 12'h010;
    ms(1);
    check(32'({irq, ref_hold, freq_cmd}), 32'h0000_3666, "held");
    rd(drso_pkg::ADDR_STAT, 32'h0000_0002, 2'h0, "status");
    rd(drso_pkg::ADDR_LIVE, 32'h0000_1666, 2'h0, "live");
    wr(drso_pkg::ADDR_MASK, 32'h0000_0000, 2'h0);
    check(32'(irq), 32'h0, "masked");
    wr(drso_pkg::ADDR_MASK, 32'h0000_0002, 2'h0);
    wr(drso_pkg::ADDR_STAT, 32'h0000_0002, 2'h0);
    check(32'(irq), 32'h0, "cleared");
    ref_in <= 12'h700;
    ms(1);
    check(32'({ref_hold, freq_cmd}), 32'h0000_0700, "above hold");
    ref_in <= 12'h800;
    ms(410);
    ref_in <= 12'h010;
    ms(1);
    check(32'(ref_hold), 32'h1, "held again");
    stop_cmd <= 1'b1;
    ms(1);
    check(32'(ref_hold), 32'h0, "stop");
    ref_in <= 12'h0C0;
    ms(410);
    stop_cmd <= 1'b0;
    ms(1);
    ref_in <= 12'h000;
    ms(1);
    check(32'(ref_hold), 32'h0, "low loss");
    wr(drso_pkg::ADDR_SHAPE, 32'h0000_0001, 2'h0);
    wr(drso_pkg::ADDR_OTCFG, 32'h0000_0003, 2'h0);
    wr(drso_pkg::ADDR_SELA, 32'h0000_000B, 2'h0);
    load_pct <= 10'd170;
    ms(50);
    check(32'(overtorque), 32'h0, "early");
    ms(60);
    check(32'({overtorque, multi_out_overtorque, inverter_off}), 32'h6, "ot");
    hi = 0;
    repeat (300 * TICK) begin
      @(posedge aclk);
      hi += int'(alarm_blink === 1'b1);
    end
    check(32'(hi > 0 && hi < 300 * TICK), 32'h1, "blink");
    load_pct <= 10'd155;
    ms(5);
    check(32'(overtorque), 32'h1, "hyst hold");
    load_pct <= 10'd149;
    ms(5);
    check(32'(overtorque), 32'h0, "hyst clear");
    load_pct <= 10'd200;
    dc_braking <= 1'b1;
    ms(110);
    check(32'(overtorque), 32'h0, "braking");
    dc_braking <= 1'b0;
    wr(drso_pkg::ADDR_OTCFG, 32'h0000_0001, 2'h0);
    ms(110);
    check(32'(overtorque), 32'h0, "not agreed");
    at_agreed_freq <= 1'b1;
    ms(110);
    check(32'(overtorque), 32'h1, "agreed");
    torque_pct <= 10'd50;
    wr(drso_pkg::ADDR_OTCFG, 32'h0000_0009, 2'h0);
    ms(5);
    check(32'(overtorque), 32'h0, "torque low");
    torque_pct <= 10'd170;
    ms(110);
    check(32'(overtorque), 32'h1, "torque high");
    wr(drso_pkg::ADDR_OTCFG, 32'h0000_0008, 2'h0);
    ms(5);
    check(32'(overtorque), 32'h0, "disabled");
    wr(drso_pkg::ADDR_OTCFG, 32'h0000_0005, 2'h0);
    ms(110);
    check(32'({fault_display, inverter_off, fault_contact}), 32'h7, "fault");
    ms(5);
    check(32'({fault_display, inverter_off, fault_contact}), 32'h7, "latched");
    load_pct <= 10'd0;
    fault_reset <= 1'b1;
    ms(1);
    fault_reset <= 1'b0;
    ms(1);
    check(32'({fault_display, inverter_off, fault_contact}), 32'h0, "reset");
    rd(drso_pkg::ADDR_STAT, 32'h0000_0007, 2'h0, "events");
    summarize();
  end
endmodule : drive_ref_shaping_overtorque_test
